// >>> hw/cpgrd_pkg.sv
// Purpose: Constants and types for the configuration protection guard.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Register offsets are byte addresses.
package cpgrd_pkg;
  localparam logic [11:0] OFS_DBGLV = 12'h000;
  localparam logic [11:0] OFS_RDLO = 12'h004;
  localparam logic [11:0] OFS_RDHI = 12'h008;
  localparam logic [11:0] OFS_WRLO = 12'h00C;
  localparam logic [11:0] OFS_WRHI = 12'h010;
  localparam logic [11:0] OFS_STATUS = 12'h014;
  localparam logic [11:0] OFS_CHECK = 12'h018;
  localparam logic [11:0] OFS_RELOAD = 12'h01C;
  localparam int LV_BIT = 2;
  localparam int RD_EE_BIT = 7;
  localparam int RD_BOOT_BIT = 6;
  localparam int WR_EE_BIT = 7;
  localparam int WR_BOOT_BIT = 6;
  localparam int WR_CFG_BIT = 5;
  localparam logic [7:0] RST_DBGLV = 8'h85;
  localparam logic [7:0] RST_GUARD_LO = 8'h0F;
  localparam logic [7:0] RST_RDHI = 8'hC0;
  localparam logic [7:0] RST_WRHI = 8'hE0;
  localparam logic [23:0] ID_FIRST = 24'h200000;
  localparam logic [23:0] ID_LAST = 24'h200007;
  localparam logic [23:0] CFG_FIRST = 24'h300000;
  localparam logic [23:0] CFG_LAST = 24'h30000F;
  localparam logic [23:0] EE_FIRST = 24'hF00000;
  localparam logic [23:0] EE_LAST = 24'hF003FF;
  localparam logic [23:0] BOOT_LAST = 24'h0007FF;
  localparam int BLOCK_SHIFT = 14;
  localparam logic [23:0] CODE_LAST = 24'h00FFFF;
  localparam logic [15:0] STAT_PROT_BIT = 16'h0001;

  typedef enum logic [2:0] {
    CPGRD_AREA_BOOT, CPGRD_AREA_CODE, CPGRD_AREA_ID,
    CPGRD_AREA_CFG, CPGRD_AREA_EE, CPGRD_AREA_NONE
  } cpgrd_area_t;

  typedef struct packed {
    logic [23:0] addr;
    logic is_write;
    logic from_prog;
    logic valid;
  } cpgrd_req_t;

  typedef struct packed {
    logic allow;
    logic deny_read;
    logic deny_write;
  } cpgrd_rsp_t;

  typedef enum logic [1:0] {
    CPGRD_MODE_RUN, CPGRD_MODE_LV, CPGRD_MODE_HV
  } cpgrd_mode_t;
endpackage : cpgrd_pkg

// >>> hw/cpgrd_guard.sv
// Purpose: Memory access guard driven by the protection configuration bytes.
// Assumes: Nonvolatile configuration bytes arrive as stable inputs; pins are asynchronous.
// Notes: Software sees and stages configuration over APB; reload re-samples the nonvolatile input bytes, not the staged values.
`timescale 1ns/1ps
module cpgrd_guard
  import cpgrd_pkg::*;
#(
  parameter int NUM_BLOCKS = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] nv_dbglv,
  input wire logic [7:0] nv_rdlo,
  input wire logic [7:0] nv_rdhi,
  input wire logic [7:0] nv_wrlo,
  input wire logic [7:0] nv_wrhi,
  input wire logic master_clear_vpp_pin,
  input wire logic prog_entry_select_pin,
  input wire cpgrd_req_t req,
  output cpgrd_rsp_t rsp,
  output logic prog_entry_select_gpio_en,
  output cpgrd_mode_t prog_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // Active configuration, sampled at reset release and on software reload.
  logic [7:0] dbglv_q, rdlo_q, rdhi_q, wrlo_q, wrhi_q;
  logic loaded_q;
  logic reload_q;
  logic apb_wr;
  logic apb_rd;
  logic [11:0] ofs;
  assign ofs = {paddr[11:2], 2'b00};
  assign apb_wr = psel & penable & pwrite;
  assign apb_rd = psel & penable & ~pwrite;
  assign pready = 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbglv_q <= RST_DBGLV;
      rdlo_q <= RST_GUARD_LO;
      rdhi_q <= RST_RDHI;
      wrlo_q <= RST_GUARD_LO;
      wrhi_q <= RST_WRHI;
      loaded_q <= 1'b0;
    end else if (!loaded_q || reload_q) begin
      // The straps are captured only after release, never under the reset itself.
      dbglv_q <= nv_dbglv;
      rdlo_q <= nv_rdlo;
      rdhi_q <= nv_rdhi;
      wrlo_q <= nv_wrlo;
      wrhi_q <= nv_wrhi;
      loaded_q <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_q <= 1'b0;
    end else begin
      reload_q <= apb_wr && ofs == OFS_RELOAD && pwdata[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a change counts once stages two and three agree.
  logic [2:0] vpp_s_q, pgm_s_q;
  logic vpp_q, pgm_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vpp_s_q <= 3'h0;
      pgm_s_q <= 3'h0;
    end else begin
      vpp_s_q <= {vpp_s_q[1:0], master_clear_vpp_pin};
      pgm_s_q <= {pgm_s_q[1:0], prog_entry_select_pin};
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vpp_q <= 1'b0;
      pgm_q <= 1'b0;
    end else begin
      if (vpp_s_q[1] == vpp_s_q[2]) vpp_q <= vpp_s_q[2];
      if (pgm_s_q[1] == pgm_s_q[2]) pgm_q <= pgm_s_q[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Programming entry selection.
  logic lv_en;
  cpgrd_mode_t mode_d;
  assign lv_en = dbglv_q[LV_BIT];
  always_comb begin
    if (vpp_q) begin
      mode_d = CPGRD_MODE_HV;
    end else if (lv_en && pgm_q) begin
      mode_d = CPGRD_MODE_LV;
    end else begin
      mode_d = CPGRD_MODE_RUN;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_mode <= CPGRD_MODE_RUN;
    end else begin
      prog_mode <= mode_d;
    end
  end
  // The select pin is a programming pin whenever low-voltage entry is enabled.
  assign prog_entry_select_gpio_en = ~lv_en;

  ////////////////////////////////////////////////////////////////////////////
  // Access check.
  cpgrd_area_t area;
  logic [1:0] blk;
  logic rd_ok, wr_ok;
  logic [NUM_BLOCKS-1:0] blk_rd_ok, blk_wr_ok;
  genvar g;
  generate
    for (g = 0; g < NUM_BLOCKS; g++) begin : g_blk
      assign blk_rd_ok[g] = rdlo_q[g];
      assign blk_wr_ok[g] = wrlo_q[g];
    end
  endgenerate

  always_comb begin
    blk = req.addr[BLOCK_SHIFT+1:BLOCK_SHIFT];
    if (req.addr <= BOOT_LAST) area = CPGRD_AREA_BOOT;
    else if (req.addr <= CODE_LAST) area = CPGRD_AREA_CODE;
    else if (req.addr >= ID_FIRST && req.addr <= ID_LAST) area = CPGRD_AREA_ID;
    else if (req.addr >= CFG_FIRST && req.addr <= CFG_LAST) area = CPGRD_AREA_CFG;
    else if (req.addr >= EE_FIRST && req.addr <= EE_LAST) area = CPGRD_AREA_EE;
    else area = CPGRD_AREA_NONE;
    case (area)
      CPGRD_AREA_BOOT: begin
        rd_ok = rdhi_q[RD_BOOT_BIT];
        wr_ok = wrhi_q[WR_BOOT_BIT];
      end
      CPGRD_AREA_CODE: begin
        rd_ok = blk_rd_ok[blk];
        wr_ok = blk_wr_ok[blk];
      end
      CPGRD_AREA_ID: begin
        rd_ok = 1'b1;
        wr_ok = 1'b1;
      end
      CPGRD_AREA_CFG: begin
        rd_ok = 1'b1;
        wr_ok = wrhi_q[WR_CFG_BIT];
      end
      CPGRD_AREA_EE: begin
        rd_ok = rdhi_q[RD_EE_BIT];
        wr_ok = wrhi_q[WR_EE_BIT];
      end
      default: begin
        rd_ok = 1'b0;
        wr_ok = 1'b0;
      end
    endcase
  end

  // Table reads by running code and programmer reads are treated alike.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp <= '0;
    end else begin
      rsp.deny_read <= req.valid & ~req.is_write & ~rd_ok;
      rsp.deny_write <= req.valid & req.is_write & ~wr_ok;
      rsp.allow <= req.valid & (req.is_write ? wr_ok : rd_ok);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB register access; staged bytes stay inside and are only read back at the check and reload offsets.
  logic any_prot;
  logic [7:0] stage_dbglv_q, stage_rdlo_q, stage_rdhi_q, stage_wrlo_q, stage_wrhi_q;
  logic cfg_locked;
  assign any_prot = ~&rdlo_q[NUM_BLOCKS-1:0] | ~rdhi_q[RD_BOOT_BIT];
  // A cleared config write guard freezes every staged byte; only high-voltage
  // entry may alter the low-voltage enable bit.
  assign cfg_locked = ~wrhi_q[WR_CFG_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_dbglv_q <= RST_DBGLV;
      stage_rdlo_q <= RST_GUARD_LO;
      stage_rdhi_q <= RST_RDHI;
      stage_wrlo_q <= RST_GUARD_LO;
      stage_wrhi_q <= RST_WRHI;
    end else if (apb_wr && !cfg_locked) begin
      case (ofs)
        OFS_DBGLV: begin
          stage_dbglv_q <= pwdata[7:0];
          if (prog_mode != CPGRD_MODE_HV) stage_dbglv_q[LV_BIT] <= stage_dbglv_q[LV_BIT];
        end
        OFS_RDLO: stage_rdlo_q <= pwdata[7:0];
        OFS_RDHI: stage_rdhi_q <= pwdata[7:0];
        OFS_WRLO: stage_wrlo_q <= pwdata[7:0];
        OFS_WRHI: stage_wrhi_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  logic [31:0] rdata_d;
  always_comb begin
    case (ofs)
      OFS_DBGLV: rdata_d = {24'h000000, dbglv_q};
      OFS_RDLO: rdata_d = {24'h000000, rdlo_q};
      OFS_RDHI: rdata_d = {24'h000000, rdhi_q};
      OFS_WRLO: rdata_d = {24'h000000, wrlo_q};
      OFS_WRHI: rdata_d = {24'h000000, wrhi_q};
      OFS_STATUS: rdata_d = {28'h0000000, cfg_locked, prog_mode, any_prot};
      OFS_CHECK: rdata_d = {stage_wrhi_q, stage_wrlo_q, stage_rdhi_q, stage_rdlo_q};
      OFS_RELOAD: rdata_d = {24'h000000, stage_dbglv_q};
      default: rdata_d = 32'h00000000;
    endcase
  end
  assign prdata = rdata_d;
  assign pslverr = psel & penable & (ofs > OFS_RELOAD);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  a_vpp_forces_hv: assert property (@(posedge pclk) disable iff (!presetn)
    vpp_q |=> prog_mode == CPGRD_MODE_HV) else $error("High level did not enter programming.");
  a_lv_off_gpio: assert property (@(posedge pclk) disable iff (!presetn)
    !lv_en |-> prog_entry_select_gpio_en) else $error("Select pin not I/O.");
  a_lv_no_gpio: assert property (@(posedge pclk) disable iff (!presetn)
    prog_mode == CPGRD_MODE_LV |-> !prog_entry_select_gpio_en) else $error("Pin I/O in LV.");
  a_blk_read: assert property (@(posedge pclk) disable iff (!presetn)
    req.valid && !req.is_write && area == CPGRD_AREA_CODE && !rdlo_q[blk] |=> rsp.deny_read)
    else $error("Protected block read allowed.");
  a_blk_write: assert property (@(posedge pclk) disable iff (!presetn)
    req.valid && req.is_write && area == CPGRD_AREA_CODE |=> rsp.deny_write == !$past(wrlo_q[blk]))
    else $error("Block write guard wrong.");
  a_boot_read: assert property (@(posedge pclk) disable iff (!presetn)
    req.valid && !req.is_write && area == CPGRD_AREA_BOOT |=> rsp.allow == $past(rdhi_q[RD_BOOT_BIT]))
    else $error("Boot read guard wrong.");
  a_ee_write: assert property (@(posedge pclk) disable iff (!presetn)
    req.valid && req.is_write && area == CPGRD_AREA_EE |=> rsp.allow == $past(wrhi_q[WR_EE_BIT]))
    else $error("EEPROM write guard wrong.");
  a_cfg_lock: assert property (@(posedge pclk) disable iff (!presetn)
    req.valid && req.is_write && area == CPGRD_AREA_CFG && !wrhi_q[WR_CFG_BIT] |=> rsp.deny_write)
    else $error("Locked config written.");
  a_id_readable: assert property (@(posedge pclk) disable iff (!presetn)
    req.valid && !req.is_write && (area == CPGRD_AREA_ID || area == CPGRD_AREA_CFG) |=> rsp.allow)
    else $error("ID or config read denied.");
  a_load_once: assert property (@(posedge pclk) disable iff (!presetn)
    !loaded_q |=> loaded_q && rdlo_q == $past(nv_rdlo)) else $error("Bits not sampled.");
endmodule : cpgrd_guard

// >>> tb/cpgrd_prog_model.sv
// Purpose: Behavioural external programmer driving the guard's access port and entry pins.
// Assumes: Requests are sampled by the guard at the rising edge after they are driven.
// Notes: A released request shows inverted fields so stale values never look valid.
`timescale 1ns/1ps
module cpgrd_prog_model
  import cpgrd_pkg::*;
(
  input wire logic pclk,
  output cpgrd_req_t req,
  output logic vpp_high,
  output logic entry_sel
);
  initial begin
    req = '0;
    vpp_high = 1'b0;
    entry_sel = 1'b0;
  end

  task automatic access(input logic [23:0] a, input logic wr, input logic fp);
    @(posedge pclk);
    req <= '{addr: a, is_write: wr, from_prog: fp, valid: 1'b1};
    @(posedge pclk);
    req <= '{addr: ~a, is_write: ~wr, from_prog: ~fp, valid: 1'b0};
  endtask : access

  localparam logic [7:0] CFG_MASK [5] = '{8'hC5, 8'h0F, 8'hC0, 8'h0F, 8'hE0};

  // Checksum as the programmer forms it; a protected part's read-out is summed as read.
  function automatic logic [15:0] checksum(input logic [15:0] code_sum,
    input logic [7:0] cfg [5], input logic [7:0] id [8], input logic prot);
    logic [15:0] s;
    s = code_sum;
    for (int i = 0; i < 5; i++) s = s + 16'(cfg[i] & CFG_MASK[i]);
    if (prot) begin
      for (int i = 0; i < 8; i++) s = s + 16'(id[i][3:0]);
    end
    return s;
  endfunction : checksum

  // The enable bit is only ever changed with the high level present.
  task automatic set_pins(input logic vpp, input logic sel);
    @(posedge pclk);
    vpp_high <= vpp;
    entry_sel <= sel;
  endtask : set_pins
endmodule : cpgrd_prog_model

// >>> tb/cpgrd_guard_tb_top.sv
// Purpose: Self-checking bench for the configuration protection guard.
// Assumes: Zero-wait APB slave; pin filter settles well within ten cycles.
// Notes: Expectations come from a bench model of the sampled configuration bytes.
`timescale 1ns/1ps
module cpgrd_guard_tb_top;
  import cpgrd_pkg::*;
  localparam logic [7:0] MASK [5] = '{8'h04, 8'h0F, 8'hC0, 8'h0F, 8'hE0};
  localparam logic [23:0] BASE [8] = '{24'h000000, 24'h000800, 24'h004000, 24'h008000,
    24'h00C000, 24'h200000, 24'h300000, 24'hF00000};
  localparam logic [23:0] SPAN [8] = '{24'h7FF, 24'h3FF, 24'h3FFF, 24'h3FFF, 24'h3FFF,
    24'h7, 24'hF, 24'h3FF};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, seed = 32'h7C58, r, q;
  logic pready, pslverr, gpio_en, e, vpp, sel;
  logic [7:0] nv [5] = '{default: 8'hFF};
  cpgrd_req_t req;
  cpgrd_rsp_t rsp;
  cpgrd_mode_t prog_mode;
  int fails = 0, comparisons = 0, cyc = 0;

  always #20 pclk = ~pclk;

  cpgrd_guard i_cpgrd_guard (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .nv_dbglv(nv[0]), .nv_rdlo(nv[1]), .nv_rdhi(nv[2]), .nv_wrlo(nv[3]),
    .nv_wrhi(nv[4]), .master_clear_vpp_pin(vpp), .prog_entry_select_pin(sel), .req(req),
    .rsp(rsp), .prog_entry_select_gpio_en(gpio_en), .prog_mode(prog_mode));
  cpgrd_prog_model i_cpgrd_prog_model (.pclk(pclk), .req(req), .vpp_high(vpp),
    .entry_sel(sel));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  function automatic logic [2:0] exp_rsp(input logic [23:0] a, input logic wr);
    logic ok;
    if (a <= BOOT_LAST) ok = wr ? nv[4][WR_BOOT_BIT] : nv[2][RD_BOOT_BIT];
    else if (a <= CODE_LAST) ok = wr ? nv[3][a[15:14]] : nv[1][a[15:14]];
    else if (a <= ID_LAST) ok = 1'b1;
    else if (a <= CFG_LAST) ok = wr ? nv[4][WR_CFG_BIT] : 1'b1;
    else ok = wr ? nv[4][WR_EE_BIT] : nv[2][RD_EE_BIT];
    return {ok, ~wr & ~ok, wr & ~ok};
  endfunction : exp_rsp

  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    comparisons++;
    if (seen !== want) begin
      fails++;
      $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] a, output logic [31:0] d,
    output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= 32'h0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    d = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    for (int it = 0; it < 8; it++) begin
      @(posedge pclk);
      presetn <= 1'b0;
      for (int j = 0; j < 5; j++) begin
        r = rnd();
        nv[j] <= r[7:0];
      end
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      for (int j = 0; j < 5; j++) begin
        apb(1'b0, 12'(4 * j), q, e);
        check(q & 32'(MASK[j]), 32'(nv[j] & MASK[j]), "config read");
      end
      apb(1'b1, OFS_RDLO, q, e);
      apb(1'b0, OFS_RDLO, q, e);
      check(q & 32'h0F, 32'(nv[1] & 8'h0F), "active after write");
      apb(1'b0, OFS_CHECK, q, e);
      check(q & 32'hFF, 32'(nv[4][WR_CFG_BIT] ? 8'h00 : RST_GUARD_LO), "staged write");
      apb(1'b0, OFS_STATUS, q, e);
      check(q, {28'h0, ~nv[4][WR_CFG_BIT], 2'b00, ~&nv[1][3:0] | ~nv[2][RD_BOOT_BIT]},
        "status");
      apb(1'b0, 12'h020, q, e);
      check({31'h0, e}, 32'h1, "unmapped error");
      check(q, 32'h0, "unmapped data");
      check({31'h0, gpio_en}, {31'h0, ~nv[0][LV_BIT]}, "select pin use");
      for (int k = 0; k < 40; k++) begin
        r = rnd();
        i_cpgrd_prog_model.access(BASE[r[2:0]] | (r[31:8] & SPAN[r[2:0]]),
          r[5] & (r[2:0] != 3'd5), r[6]);
        #1;
        check(32'(rsp), 32'(exp_rsp(req.addr ^ 24'hFFFFFF, ~req.is_write)), "guard");
      end
      for (int p = 0; p < 4; p++) begin
        i_cpgrd_prog_model.set_pins(p[1], p[0]);
        repeat (10) @(posedge pclk);
        check(32'(prog_mode), p[1] ? 32'(CPGRD_MODE_HV) : (p[0] & nv[0][LV_BIT]) ?
          32'(CPGRD_MODE_LV) : 32'(CPGRD_MODE_RUN), "entry mode");
      end
      i_cpgrd_prog_model.set_pins(1'b0, 1'b0);
      repeat (10) @(posedge pclk);
      $display("test %0d done", it);
    end
    final_report();
  end
endmodule : cpgrd_guard_tb_top
